// ==== hdl/dstg_slave_framer.sv ====
`timescale 1ns/1ns
`include "dstg_params.svh"
module dstg_slave_framer #(
  parameter int MAX_DATA = 32,
  parameter int DIV_W    = 16,
  parameter int DLY_W    = 24
) (
  input  wire logic             ref_clk,
  input  wire logic             arst_n,
  input  wire logic             rx_in,
  output logic                  tx_out,
  output logic                  tx_oe,
  input  wire logic             proto_sel,
  input  wire logic [6:0]       node_addr,
  input  wire logic [DIV_W-1:0] bit_div,
  input  wire logic [1:0]       parity_mode,
  input  wire logic             two_stop,
  input  wire logic [DLY_W-1:0] min_resp_delay,
  input  wire logic [DLY_W-1:0] max_char_gap,
  input  wire logic [15:0]      status_word,
  input  wire logic [15:0]      out_freq,
  output logic [15:0]           ctrl_word,
  output logic [15:0]           bus_ref,
  output logic                  cmd_valid,
  output logic                  gap_timeout,
  output logic                  frame_drop
);
  localparam int AW = $clog2(MAX_DATA);

  dstg_char_if #(.DIV_W(DIV_W)) ch ();

  dstg_serdes #(.DIV_W(DIV_W)) u_serdes (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .ch      (ch),
    .rx_in   (rx_in),
    .tx_out  (tx_out),
    .tx_oe   (tx_oe)
  );

  assign ch.bit_div     = bit_div;
  assign ch.parity_mode = parity_mode;
  assign ch.two_stop    = two_stop;

  dstg_pkg::dstg_state_type state_q;
  logic [7:0]       len_q;
  logic [7:0]       addr_q;
  logic [7:0]       idx_q;
  logic [7:0]       bcc_q;
  logic [DLY_W-1:0] gap_cnt_q;
  logic [DLY_W-1:0] dly_cnt_q;
  logic [7:0]       mem [MAX_DATA];
  logic [7:0]       ndata;
  logic [7:0]       pcd_base;
  logic [7:0]       dpos;
  logic [7:0]       ppos;
  logic [7:0]       last_idx;
  logic [7:0]       tx_sel;
  logic [AW-1:0]    pb;
  logic             receiving;
  logic             gap_over;
  logic             abort;
  logic             rx_ok;
  logic             len_ok;
  logic             addr_hit;
  logic             addr_bcast;
  logic             bcc_ok;
  logic             tx_go;

  // ===================================================================
  // decode
  assign ndata     = len_q - `DSTG_LEN_OVERHEAD;
  assign pcd_base  = (ndata >= `DSTG_PCD_BYTES) ?
                     ndata - `DSTG_PCD_BYTES : 8'h00;
  assign pb        = pcd_base[AW-1:0];
  assign last_idx  = len_q + `DSTG_IDX_LEN;
  assign dpos      = idx_q - `DSTG_IDX_DATA;
  assign ppos      = dpos - pcd_base;
  assign receiving = (state_q == dstg_pkg::st_len) ||
                     (state_q == dstg_pkg::st_addr) ||
                     (state_q == dstg_pkg::st_data) ||
                     (state_q == dstg_pkg::st_check);
  assign gap_over  = gap_cnt_q >= max_char_gap;
  assign abort     = gap_over || (ch.rx_valid && ch.rx_err);
  assign rx_ok     = ch.rx_valid && !ch.rx_err;
  // long and text telegrams are held whole up to MAX_DATA data bytes
  assign len_ok    = (ch.rx_byte >= `DSTG_LEN_MIN) &&
                     (ch.rx_byte - `DSTG_LEN_OVERHEAD <= 8'(MAX_DATA));
  assign bcc_ok    = (bcc_q == ch.rx_byte);
  // a character arriving mid-response holds the driver off
  assign tx_go     = (state_q == dstg_pkg::st_send) &&
                     !ch.tx_busy && !ch.tx_start &&
                     !ch.rx_busy;

  // node address zero is never matched, so an unset node stays quiet
  always_comb begin
    addr_hit   = 1'b0;
    addr_bcast = 1'b0;
    if (addr_q[`DSTG_ADDR_WIDE_BIT]) begin
      addr_bcast = (addr_q[6:0] == `DSTG_ADDR_NONE);
      addr_hit   = (addr_q[6:0] == node_addr) &&
                   (node_addr != `DSTG_ADDR_NONE);
    end else begin
      addr_bcast = addr_q[`DSTG_ADDR_BCAST_BIT];
      addr_hit   = !addr_bcast && (addr_q[4:0] == node_addr[4:0]) &&
                   (node_addr[6:5] == `DSTG_ADDR_HI_ZERO) &&
                   (node_addr != `DSTG_ADDR_NONE);
    end
  end

  // response: parameter field answers "no response", process data last
  always_comb begin
    tx_sel = 8'h00;
    if (idx_q == 8'h00)
      tx_sel = `DSTG_START_CHAR;
    else if (idx_q == `DSTG_IDX_LEN)
      tx_sel = len_q;
    else if (idx_q == `DSTG_IDX_ADDR)
      tx_sel = addr_q;
    else if (idx_q == last_idx)
      tx_sel = bcc_q;
    else if (dpos >= pcd_base) begin
      unique case (ppos[1:0])
        2'h0: tx_sel = status_word[15:8];
        2'h1: tx_sel = status_word[7:0];
        2'h2: tx_sel = out_freq[15:8];
        2'h3: tx_sel = out_freq[7:0];
      endcase
    end
  end

  // ===================================================================
  // telegram sequencer
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= dstg_pkg::st_idle;
      len_q   <= 8'h00;
      addr_q  <= 8'h00;
      idx_q   <= 8'h00;
      bcc_q   <= `DSTG_BCC_INIT;
    end else if (!proto_sel) begin
      state_q <= dstg_pkg::st_idle;
    end else begin
      unique case (state_q)
        dstg_pkg::st_idle:
          if (rx_ok && ch.rx_byte == `DSTG_START_CHAR) begin
            bcc_q   <= `DSTG_BCC_INIT ^ ch.rx_byte;
            state_q <= dstg_pkg::st_len;
          end
        dstg_pkg::st_len:
          if (abort)
            state_q <= gap_over ? dstg_pkg::st_idle : dstg_pkg::st_skip;
          else if (ch.rx_valid) begin
            len_q   <= ch.rx_byte;
            bcc_q   <= bcc_q ^ ch.rx_byte;
            state_q <= len_ok ? dstg_pkg::st_addr : dstg_pkg::st_skip;
          end
        dstg_pkg::st_addr:
          if (abort)
            state_q <= gap_over ? dstg_pkg::st_idle : dstg_pkg::st_skip;
          else if (ch.rx_valid) begin
            addr_q  <= ch.rx_byte;
            bcc_q   <= bcc_q ^ ch.rx_byte;
            idx_q   <= 8'h00;
            state_q <= dstg_pkg::st_data;
          end
        dstg_pkg::st_data:
          if (abort)
            state_q <= gap_over ? dstg_pkg::st_idle : dstg_pkg::st_skip;
          else if (ch.rx_valid) begin
            bcc_q <= bcc_q ^ ch.rx_byte;
            idx_q <= idx_q + 8'h01;
            if (idx_q == ndata - 8'h01)
              state_q <= dstg_pkg::st_check;
          end
        dstg_pkg::st_check:
          if (abort)
            state_q <= gap_over ? dstg_pkg::st_idle : dstg_pkg::st_skip;
          else if (ch.rx_valid) begin
            if (bcc_ok && addr_hit)
              state_q <= dstg_pkg::st_delay;
            else if (bcc_ok && addr_bcast)
              state_q <= dstg_pkg::st_idle;
            else
              state_q <= dstg_pkg::st_skip;
          end
        // wait for line silence so data bytes are not taken as a start
        dstg_pkg::st_skip:
          if (gap_over)
            state_q <= dstg_pkg::st_idle;
        dstg_pkg::st_delay:
          if (dly_cnt_q >= min_resp_delay && !ch.rx_busy) begin
            state_q <= dstg_pkg::st_send;
            idx_q   <= 8'h00;
            bcc_q   <= `DSTG_BCC_INIT;
          end
        dstg_pkg::st_send:
          if (tx_go) begin
            bcc_q <= bcc_q ^ tx_sel;
            idx_q <= idx_q + 8'h01;
            if (idx_q == last_idx)
              state_q <= dstg_pkg::st_idle;
          end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (state_q == dstg_pkg::st_data && rx_ok && !gap_over)
      mem[idx_q[AW-1:0]] <= ch.rx_byte;
  end

  // ===================================================================
  // timers: both count clock cycles
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n)
      gap_cnt_q <= '0;
    else if (ch.rx_busy || ch.rx_valid ||
             !(receiving || state_q == dstg_pkg::st_skip))
      gap_cnt_q <= '0;
    else if (gap_cnt_q != '1)
      gap_cnt_q <= gap_cnt_q + 1'b1;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n)
      dly_cnt_q <= '0;
    else if (state_q != dstg_pkg::st_delay)
      dly_cnt_q <= '0;
    else if (dly_cnt_q != '1)
      dly_cnt_q <= dly_cnt_q + 1'b1;
  end

  // ===================================================================
  // transmit request towards the character engine
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ch.tx_start <= 1'b0;
      ch.tx_byte  <= 8'h00;
    end else begin
      ch.tx_start <= tx_go;
      if (tx_go)
        ch.tx_byte <= tx_sel;
    end
  end

  // ===================================================================
  // results towards the drive
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_word   <= 16'h0000;
      bus_ref     <= 16'h0000;
      cmd_valid   <= 1'b0;
      gap_timeout <= 1'b0;
      frame_drop  <= 1'b0;
    end else begin
      cmd_valid   <= 1'b0;
      gap_timeout <= receiving && gap_over && proto_sel;
      frame_drop  <= 1'b0;
      if (proto_sel && state_q == dstg_pkg::st_check && rx_ok &&
          !gap_over) begin
        if (bcc_ok && (addr_hit || addr_bcast) &&
            ndata >= `DSTG_PCD_BYTES) begin
          cmd_valid <= 1'b1;
          ctrl_word <= {mem[pb], mem[pb + AW'(1)]};
          bus_ref   <= {mem[pb + AW'(2)], mem[pb + AW'(3)]};
        end else if (!bcc_ok) begin
          frame_drop <= 1'b1;
        end
      end
    end
  end

  // ===================================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  sequence s_enter_send;
    state_q == dstg_pkg::st_delay ##1 state_q == dstg_pkg::st_send;
  endsequence

  property p_only_on_request;
    ch.tx_start |-> $past(state_q) == dstg_pkg::st_send;
  endproperty
  a_only_on_request: assert property (p_only_on_request)
    else $error("transmit outside response phase");

  property p_no_tx_while_rx;
    ch.tx_start |-> !ch.rx_busy;
  endproperty
  a_no_tx_while_rx: assert property (p_no_tx_while_rx)
    else $error("transmit started while receiving");

  property p_start_char_first;
    s_enter_send |-> ##[1:3] (ch.tx_start && ch.tx_byte == `DSTG_START_CHAR);
  endproperty
  a_start_char_first: assert property (p_start_char_first)
    else $error("response does not open with start char");

  property p_min_delay;
    s_enter_send |-> $past(dly_cnt_q) >= $past(min_resp_delay);
  endproperty
  a_min_delay: assert property (p_min_delay)
    else $error("response started before minimum delay");

  property p_gap_abort;
    gap_timeout |-> state_q == dstg_pkg::st_idle;
  endproperty
  a_gap_abort: assert property (p_gap_abort)
    else $error("telegram kept after gap timeout");

  property p_bad_check_dropped;
    (proto_sel && state_q == dstg_pkg::st_check && rx_ok && !gap_over &&
     !bcc_ok) |=> (state_q == dstg_pkg::st_skip && frame_drop);
  endproperty
  a_bad_check_dropped: assert property (p_bad_check_dropped)
    else $error("telegram with bad check byte not dropped");

  property p_addr_echo;
    (ch.tx_start && idx_q == `DSTG_IDX_DATA) |-> ch.tx_byte == addr_q;
  endproperty
  a_addr_echo: assert property (p_addr_echo)
    else $error("address byte not echoed");

  property p_bcc_seed;
    (state_q == dstg_pkg::st_idle && rx_ok && proto_sel &&
     ch.rx_byte == `DSTG_START_CHAR) |=> bcc_q == `DSTG_START_CHAR;
  endproperty
  a_bcc_seed: assert property (p_bcc_seed)
    else $error("check byte not seeded from zero");

  property p_proto_off;
    !proto_sel |=> state_q == dstg_pkg::st_idle;
  endproperty
  a_proto_off: assert property (p_proto_off)
    else $error("framer active while deselected");
endmodule

// ==== common/dstg_params.svh ====
`ifndef DSTG_PARAMS_SVH
`define DSTG_PARAMS_SVH

// =====================================================================
// telegram framing
`define DSTG_START_CHAR    8'h02
`define DSTG_LEN_OVERHEAD  8'h02
`define DSTG_LEN_MIN       8'h03
`define DSTG_PCD_BYTES     8'h04
`define DSTG_IDX_LEN       8'h01
`define DSTG_IDX_ADDR      8'h02
`define DSTG_IDX_DATA      8'h03
`define DSTG_BCC_INIT      8'h00

// =====================================================================
// address byte layout
`define DSTG_ADDR_WIDE_BIT  7
`define DSTG_ADDR_BCAST_BIT 5
`define DSTG_ADDR_NONE      7'h00
`define DSTG_ADDR_HI_ZERO   2'h0

// =====================================================================
// character format
`define DSTG_PAR_EVEN  2'h0
`define DSTG_PAR_ODD   2'h1
`define DSTG_PAR_NONE  2'h2
`define DSTG_LAST_BIT  3'h7

`endif

// ==== common/dstg_pkg.sv ====
package dstg_pkg;

  typedef enum logic [2:0] {
    st_idle, st_len, st_addr, st_data, st_check, st_skip, st_delay, st_send
  } dstg_state_type;

  typedef enum logic [2:0] {
    ser_idle, ser_start, ser_data, ser_par, ser_stop
  } dstg_ser_type;

endpackage

// ==== common/dstg_char_if.sv ====
`timescale 1ns/1ns
interface dstg_char_if #(parameter int DIV_W = 16);
  logic [DIV_W-1:0] bit_div;
  logic [1:0]       parity_mode;
  logic             two_stop;
  logic [7:0]       rx_byte;
  logic             rx_valid;
  logic             rx_err;
  logic             rx_busy;
  logic [7:0]       tx_byte;
  logic             tx_start;
  logic             tx_busy;

  modport ser (
    input  bit_div, parity_mode, two_stop, tx_byte, tx_start,
    output rx_byte, rx_valid, rx_err, rx_busy, tx_busy
  );
  modport frm (
    output bit_div, parity_mode, two_stop, tx_byte, tx_start,
    input  rx_byte, rx_valid, rx_err, rx_busy, tx_busy
  );
endinterface

// ==== hdl/dstg_serdes.sv ====
`timescale 1ns/1ns
`include "dstg_params.svh"
module dstg_serdes #(
  parameter int DIV_W = 16
) (
  input  wire logic ref_clk,
  input  wire logic arst_n,
  dstg_char_if.ser  ch,
  input  wire logic rx_in,
  output logic      tx_out,
  output logic      tx_oe
);
  dstg_pkg::dstg_ser_type rx_st_q;
  dstg_pkg::dstg_ser_type tx_st_q;
  logic [DIV_W-1:0]       rx_cnt_q;
  logic [DIV_W-1:0]       tx_cnt_q;
  logic [2:0]             rx_n_q;
  logic [2:0]             tx_n_q;
  logic [7:0]             rx_sh_q;
  logic [7:0]             tx_sh_q;
  logic [7:0]             tx_hold_q;
  logic                   rx_par_q;
  logic                   rx_perr_q;
  logic                   tx_stops_q;
  logic                   odd;

  assign odd        = (ch.parity_mode == `DSTG_PAR_ODD);
  assign ch.rx_busy = (rx_st_q != dstg_pkg::ser_idle);
  assign ch.tx_busy = (tx_st_q != dstg_pkg::ser_idle);

  // ===================================================================
  // receiver: samples at mid-bit, bit time set by bit_div
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_st_q   <= dstg_pkg::ser_idle;
      rx_cnt_q  <= '0;
      rx_n_q    <= 3'h0;
      rx_sh_q   <= 8'h00;
      rx_par_q  <= 1'b0;
      rx_perr_q <= 1'b0;
      ch.rx_valid <= 1'b0;
      ch.rx_err   <= 1'b0;
      ch.rx_byte  <= 8'h00;
    end else begin
      ch.rx_valid <= 1'b0;
      if (rx_st_q == dstg_pkg::ser_idle) begin
        if (!rx_in) begin
          rx_st_q  <= dstg_pkg::ser_start;
          rx_cnt_q <= ch.bit_div >> 1;
        end
      end else if (rx_cnt_q != '0) begin
        rx_cnt_q <= rx_cnt_q - 1'b1;
      end else begin
        rx_cnt_q <= ch.bit_div - 1'b1;
        unique case (rx_st_q)
          dstg_pkg::ser_start: begin
            // a start bit gone by mid-bit is a glitch, not a character
            rx_st_q   <= rx_in ? dstg_pkg::ser_idle : dstg_pkg::ser_data;
            rx_n_q    <= 3'h0;
            rx_par_q  <= 1'b0;
            rx_perr_q <= 1'b0;
          end
          dstg_pkg::ser_data: begin
            rx_sh_q  <= {rx_in, rx_sh_q[7:1]};
            rx_par_q <= rx_par_q ^ rx_in;
            rx_n_q   <= rx_n_q + 1'b1;
            if (rx_n_q == `DSTG_LAST_BIT)
              rx_st_q <= (ch.parity_mode == `DSTG_PAR_NONE) ?
                         dstg_pkg::ser_stop : dstg_pkg::ser_par;
          end
          dstg_pkg::ser_par: begin
            rx_perr_q <= (rx_par_q ^ rx_in) != odd;
            rx_st_q   <= dstg_pkg::ser_stop;
          end
          default: begin
            // one stop bit is checked even when two are sent
            ch.rx_valid <= 1'b1;
            ch.rx_err   <= rx_perr_q | !rx_in;
            ch.rx_byte  <= rx_sh_q;
            rx_st_q     <= dstg_pkg::ser_idle;
          end
        endcase
      end
    end
  end

  // ===================================================================
  // transmitter: driver enabled only for the character itself
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_st_q    <= dstg_pkg::ser_idle;
      tx_cnt_q   <= '0;
      tx_n_q     <= 3'h0;
      tx_sh_q    <= 8'h00;
      tx_hold_q  <= 8'h00;
      tx_stops_q <= 1'b0;
      tx_out     <= 1'b1;
      tx_oe      <= 1'b0;
    end else if (tx_st_q == dstg_pkg::ser_idle) begin
      if (ch.tx_start) begin
        tx_st_q   <= dstg_pkg::ser_start;
        tx_cnt_q  <= ch.bit_div - 1'b1;
        tx_sh_q   <= ch.tx_byte;
        tx_hold_q <= ch.tx_byte;
        tx_out    <= 1'b0;
        tx_oe     <= 1'b1;
      end
    end else if (tx_cnt_q != '0) begin
      tx_cnt_q <= tx_cnt_q - 1'b1;
    end else begin
      tx_cnt_q <= ch.bit_div - 1'b1;
      unique case (tx_st_q)
        dstg_pkg::ser_start: begin
          tx_out  <= tx_sh_q[0];
          tx_sh_q <= tx_sh_q >> 1;
          tx_n_q  <= 3'h0;
          tx_st_q <= dstg_pkg::ser_data;
        end
        dstg_pkg::ser_data: begin
          tx_n_q <= tx_n_q + 1'b1;
          if (tx_n_q != `DSTG_LAST_BIT) begin
            tx_out  <= tx_sh_q[0];
            tx_sh_q <= tx_sh_q >> 1;
          end else if (ch.parity_mode == `DSTG_PAR_NONE) begin
            tx_out     <= 1'b1;
            tx_stops_q <= 1'b0;
            tx_st_q    <= dstg_pkg::ser_stop;
          end else begin
            tx_out  <= (^tx_hold_q) ^ odd;
            tx_st_q <= dstg_pkg::ser_par;
          end
        end
        dstg_pkg::ser_par: begin
          tx_out     <= 1'b1;
          tx_stops_q <= 1'b0;
          tx_st_q    <= dstg_pkg::ser_stop;
        end
        default: begin
          if (ch.two_stop && !tx_stops_q) begin
            tx_stops_q <= 1'b1;
          end else begin
            tx_oe   <= 1'b0;
            tx_st_q <= dstg_pkg::ser_idle;
          end
        end
      endcase
    end
  end

  // ===================================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  property p_tx_parity;
    tx_st_q == dstg_pkg::ser_par |-> tx_out == ((^tx_hold_q) ^ odd);
  endproperty
  a_tx_parity: assert property (p_tx_parity)
    else $error("transmitted parity bit wrong");

  property p_tx_start_low;
    (tx_st_q == dstg_pkg::ser_idle && ch.tx_start) |=> (tx_oe && !tx_out);
  endproperty
  a_tx_start_low: assert property (p_tx_start_low)
    else $error("start bit not driven low");
endmodule

// ==== dv/dstg_master_model.sv ====
`timescale 1ns/1ns
// =====
// polling master: sole initiator, idle-high line when not sending
module dstg_master_model #(
  parameter int BIT_DIV = 8
) (
  input  wire logic ref_clk,
  input  wire logic tx_out,
  input  wire logic tx_oe,
  input  wire logic par_odd,
  output logic      line_q
);
  logic [7:0] rx_q[$];
  logic       sending;
  int         fmt_err;
  int         clash;

  initial begin
    line_q  = 1'b1;
    sending = 1'b0;
    fmt_err = 0;
    clash   = 0;
  end

  task automatic send_byte(input logic [7:0] b);
    logic [10:0] fr;
    fr = {1'b1, ^b ^ par_odd, b, 1'b0};
    sending = 1'b1;
    for (int i = 0; i < 11; i++) begin
      @(negedge ref_clk);
      line_q = fr[i];
      repeat (BIT_DIV - 1) @(negedge ref_clk);
    end
    sending = 1'b0;
  endtask

  // =====
  // response capture, mid-bit sampling
  always @(posedge ref_clk) begin
    if (sending && tx_oe === 1'b1) clash++;
  end

  initial forever begin
    logic [8:0] sh;
    @(posedge ref_clk);
    if (tx_oe === 1'b1 && tx_out === 1'b0) begin
      repeat (BIT_DIV / 2) @(posedge ref_clk);
      for (int i = 0; i < 9; i++) begin
        repeat (BIT_DIV) @(posedge ref_clk);
        sh[i] = tx_out;
      end
      if (^sh !== par_odd) fmt_err++;
      repeat (BIT_DIV) @(posedge ref_clk);
      if (tx_out !== 1'b1) fmt_err++;
      rx_q.push_back(sh[7:0]);
    end
  end
endmodule

// ==== dv/dstg_slave_framer_tb_top.sv ====
`timescale 1ns/1ns
module dstg_slave_framer_tb_top;
  localparam int BD  = 8;
  localparam int DLY = 40;
  logic        ref_clk;
  logic        arst_n;
  logic        rx_in;
  logic        tx_out;
  logic        tx_oe;
  logic        proto_sel;
  logic [6:0]  node_addr;
  logic [15:0] bit_div;
  logic [1:0]  parity_mode;
  logic        two_stop;
  logic [23:0] min_resp_delay;
  logic [23:0] max_char_gap;
  logic [15:0] status_word;
  logic [15:0] out_freq;
  logic [15:0] ctrl_word;
  logic [15:0] bus_ref;
  logic        cmd_valid;
  logic        gap_timeout;
  logic        frame_drop;
  logic        oe_d;
  int          err_total;
  int          samples_checked;
  int          cyc;
  int          cv_n;
  int          fd_n;
  int          gt_n;
  int          g0;
  int          cv_at;
  int          rise_at;
  int          oe_run;
  int          oe_last;

  dstg_slave_framer uut (
    .ref_clk, .arst_n, .rx_in, .tx_out, .tx_oe, .proto_sel, .node_addr,
    .bit_div, .parity_mode, .two_stop, .min_resp_delay, .max_char_gap,
    .status_word, .out_freq, .ctrl_word, .bus_ref, .cmd_valid,
    .gap_timeout, .frame_drop
  );
  dstg_master_model #(.BIT_DIV(BD)) mdl (
    .ref_clk, .tx_out, .tx_oe, .par_odd(parity_mode == 2'h1),
    .line_q(rx_in)
  );

  // =====
  // clock, pulse counters, hang guard
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  always @(negedge ref_clk) begin
    cyc++;
    if (cmd_valid === 1'b1) begin
      cv_n++;
      cv_at   = cyc;
      rise_at = 0;
    end
    if (tx_oe === 1'b1 && oe_d !== 1'b1 && rise_at == 0) rise_at = cyc;
    // driver-on time of the last character, in clock cycles
    if (tx_oe === 1'b1) oe_run++;
    else if (oe_d === 1'b1) begin
      oe_last = oe_run;
      oe_run  = 0;
    end
    oe_d = tx_oe;
    if (frame_drop === 1'b1) fd_n++;
    if (gap_timeout === 1'b1) gt_n++;
    if (cyc == 60000) begin
      err_total++;
      end_sim();
    end
  end

  // =====
  // access tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic req(input logic [7:0] adr, input int nz,
                     input logic [15:0] cw, input logic [15:0] rf,
                     input logic bad);
    logic [7:0] t[$];
    logic [7:0] x;
    t = {8'h02, 8'(nz + 6), adr};
    repeat (nz) t.push_back(8'h11);
    t.push_back(cw[15:8]);
    t.push_back(cw[7:0]);
    t.push_back(rf[15:8]);
    t.push_back(rf[7:0]);
    x = 8'h00;
    foreach (t[i]) x ^= t[i];
    t.push_back(x ^ {7'h00, bad});
    foreach (t[i]) mdl.send_byte(t[i]);
  endtask

  task automatic resp(input logic [7:0] adr, input int nz, input int n);
    logic [7:0] e[$];
    logic [7:0] x;
    for (int i = 0; i < 4000 && mdl.rx_q.size() < n; i++)
      @(posedge ref_clk);
    repeat (300) @(posedge ref_clk);
    chk(mdl.rx_q.size(), n);
    e = {8'h02, 8'(nz + 6), adr};
    repeat (nz) e.push_back(8'h00);
    e.push_back(status_word[15:8]);
    e.push_back(status_word[7:0]);
    e.push_back(out_freq[15:8]);
    e.push_back(out_freq[7:0]);
    x = 8'h00;
    foreach (e[i]) x ^= e[i];
    e.push_back(x);
    if (n > 0) foreach (e[i]) chk(mdl.rx_q[i], e[i]);
    mdl.rx_q.delete();
  endtask

  task automatic end_sim;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    arst_n      = 1'b0;
    proto_sel   = 1'b1;
    node_addr   = 7'h05;
    status_word = 16'h1234;
    out_freq    = 16'h5678;
    bit_div        = 16'(BD);
    parity_mode    = 2'h0;
    two_stop       = 1'b0;
    min_resp_delay = 24'(DLY);
    max_char_gap   = 24'h0000c8;
    repeat (10) @(negedge ref_clk);
    arst_n = 1'b1;
    repeat (2) @(negedge ref_clk);
    req(8'h85, 0, 16'h047c, 16'h2000, 1'b0);
    resp(8'h85, 0, 8);
    chk(ctrl_word, 16'h047c);
    chk(bus_ref, 16'h2000);
    chk(16'(rise_at - cv_at >= DLY && rise_at - cv_at <= DLY + 6), 1);
    chk(16'(oe_last), 16'(11 * BD));
    req(8'h05, 8, 16'h0001, 16'h4000, 1'b0);
    resp(8'h05, 8, 16);
    chk(bus_ref, 16'h4000);
    req(8'h85, 0, 16'h1111, 16'h2222, 1'b1);
    resp(8'h85, 0, 0);
    chk(fd_n, 1);
    chk(ctrl_word, 16'h0001);
    req(8'h86, 0, 16'h1111, 16'h2222, 1'b0);
    resp(8'h86, 0, 0);
    req(8'h80, 0, 16'h0002, 16'h0003, 1'b0);
    resp(8'h80, 0, 0);
    req(8'h20, 0, 16'h0004, 16'h0005, 1'b0);
    resp(8'h20, 0, 0);
    chk(cv_n, 4);
    @(negedge ref_clk);
    proto_sel = 1'b0;
    req(8'h85, 0, 16'h0006, 16'h0007, 1'b0);
    resp(8'h85, 0, 0);
    chk(cv_n, 4);
    @(negedge ref_clk);
    proto_sel = 1'b1;
    g0 = gt_n;
    mdl.send_byte(8'h02);
    mdl.send_byte(8'h06);
    repeat (400) @(negedge ref_clk);
    chk(gt_n - g0, 1);
    req(8'h85, 0, 16'h0008, 16'h0009, 1'b0);
    resp(8'h85, 0, 8);
    @(negedge ref_clk);
    parity_mode = 2'h1;
    two_stop    = 1'b1;
    req(8'h85, 0, 16'h0a0b, 16'h0c0d, 1'b0);
    resp(8'h85, 0, 8);
    chk(ctrl_word, 16'h0a0b);
    chk(16'(oe_last), 16'(12 * BD));
    chk(mdl.fmt_err, 0);
    chk(mdl.clash, 0);
    end_sim();
  end
endmodule
